// ==== tfc_control_regs.sv ====
// tape formatter control and check-character registers with command gating
// assumes command, bus and frame counter strobes are one-cycle pulses on sys_clk;
// track loss arrives from transport pins and is synchronised here
`timescale 1ns/10ps
module tfc_control_regs #(
  parameter bit FORMATTER_VARIANT_B = 1'b0
) (
  input  wire logic                        sys_clk,
  input  wire logic                        reset,
  input  wire logic [4:0]                  regSel,
  input  wire logic                        regWrite,
  input  wire logic [15:0]                 regWrData,
  output      logic [15:0]                 regRdData,
  input  wire logic                        initPulse,
  input  wire logic                        driveClear,
  input  wire tfc_pkg::tfc_cmd_type        cmd,
  input  wire tfc_pkg::tfc_err_type        errIn,
  input  wire logic                        frameCounterWritten,
  input  wire logic                        frameCounterRollover,
  input  wire logic                        endOfRecord,
  input  wire logic                        runLine,
  input  wire logic                        driveReady,
  input  wire logic [tfc_pkg::TRACKS-1:0]  trackLossPins,
  input  wire logic [8:0]                  nrzCheckChar,
  output      tfc_pkg::tfc_cfg_type        cfg,
  output      tfc_pkg::tfc_evt_type        evt,
  output      logic                        frameCountLoaded,
  output      logic [8:0]                  checkField,
  output      logic                        checkValid
);
  import tfc_pkg::*;

  typedef struct packed {
    logic [2:0]        slave;
    logic              evenParity;
    logic [3:0]        format;
    logic [2:0]        densitySelect;
    logic              inhibitShort;
    logic              abortOnWrErr;
    logic              frame_count_loaded;
    logic              ignore_frame_count;
    tfc_op_type        op;
    logic              opWrite;
    logic              opRead;
    logic              opPe;
    logic [TRACKS-1:0] deadTrack;
    logic              ckPending;
    logic [8:0]        ckField;
    logic              ckValid;
    logic              dryQ;
    logic [7:0]        waitCnt;
    tfc_evt_type       evt;
    logic [15:0]       rdData;
  } tfc_state_type;

  tfc_state_type stQ;
  tfc_state_type stD;
  logic [TRACKS-1:0] trackLoss;

  localparam logic [7:0] WAIT_LAST = 8'(RUN_DROP_CYCLES - 1);

  function automatic logic isPe(input logic [2:0] density_select);
    isPe = (density_select >= DEN_PE_FIRST);
  endfunction : isPe

  function automatic logic fmtOk(input logic [3:0] f);
    if (FORMATTER_VARIANT_B) begin
      fmtOk = (f >= FMT_B_FIRST) && (f != FMT_RESERVED);
    end else begin
      fmtOk = (f <= FMT_A_LAST);
    end
  endfunction : fmtOk

  tfc_pin_sync u_sync (
    .sys_clk (sys_clk),
    .reset   (reset),
    .pinIn   (trackLossPins),
    .pinOut  (trackLoss)
  );

  logic tcHit;
  logic motion;
  logic xfer;
  logic anyWrErr;
  logic tcWr;
  logic clrAll;

  always_comb begin
    tcHit    = (regSel == TFC_SEL_TAPE_CONTROL);
    tcWr     = regWrite && tcHit;
    motion   = cmd.space || cmd.read || cmd.write;
    xfer     = cmd.read || cmd.write;
    anyWrErr = |errIn;
    clrAll   = initPulse || driveClear;

    stD      = stQ;
    stD.evt  = '0;
    stD.dryQ = driveReady;

    // software fields; init and drive clear leave them alone
    if (tcWr) begin
      stD.slave         = regWrData[TC_SLAVE_LSB +: 3];
      stD.evenParity    = regWrData[TC_EVEN_PAR];
      stD.format        = regWrData[TC_FMT_LSB +: 4];
      stD.densitySelect = regWrData[TC_DEN_LSB +: 3];
      stD.inhibitShort  = regWrData[TC_INH_SHORT];
      stD.abortOnWrErr  = regWrData[TC_ABORT_WERR];
      stD.ignore_frame_count           = regWrData[TC_IFC];
    end

    // frame-count-loaded: the write completing wins over any clear
    if (frameCounterRollover || clrAll) begin
      stD.frame_count_loaded = 1'b0;
    end
    if (frameCounterWritten) begin
      stD.frame_count_loaded = 1'b1;
    end

    case (stQ.op)
      OP_IDLE: begin
        stD.waitCnt = '0;
        if (cmd.load && cmd.go && !clrAll) begin
          if (xfer && !fmtOk(stQ.format)) begin
            stD.evt.formatError = 1'b1;
            stD.evt.abort       = 1'b1;
          end else if (motion && !stQ.frame_count_loaded && !stQ.ignore_frame_count) begin
            stD.evt.nonexecutableFunction = 1'b1;
            stD.evt.abort                 = 1'b1;
          end else if (motion) begin
            stD.evt.start = 1'b1;
            stD.op        = OP_RUN;
            stD.opWrite   = cmd.write;
            stD.opRead    = cmd.read;
            stD.opPe      = isPe(stQ.densitySelect);
            stD.deadTrack = '0;
          end
        end
      end
      OP_RUN: begin
        if (stQ.opRead && stQ.opPe) begin
          stD.deadTrack = stQ.deadTrack | trackLoss;
        end
        if (clrAll) begin
          stD.evt.abort = 1'b1;
          stD.op        = OP_IDLE;
        end else if (stQ.opWrite && stQ.abortOnWrErr && anyWrErr) begin
          stD.evt.abort = 1'b1;
          stD.op        = OP_IDLE;
        end else if (frameCounterRollover) begin
          // overflow ends the operation even when the count is ignored
          stD.evt.endOfBlockSignal = 1'b1;
          stD.op                   = OP_WAIT;
        end else if (endOfRecord) begin
          // record shorter than the loaded count
          if (!stQ.ignore_frame_count && !stQ.inhibitShort) begin
            stD.evt.frameCountError = 1'b1;
          end
          stD.evt.endOfBlockSignal = 1'b1;
          stD.op                   = OP_WAIT;
        end
      end
      OP_WAIT: begin
        if (!runLine || clrAll) begin
          stD.op = OP_END;
        end else if (stQ.waitCnt == WAIT_LAST) begin
          // controller kept run up; signal completion another way
          stD.evt.frameCountError = 1'b1;
          stD.op                  = OP_END;
        end else begin
          stD.waitCnt = stQ.waitCnt + 8'h01;
        end
      end
      OP_END: begin
        stD.evt.done  = 1'b1;
        stD.ckPending = stQ.opRead || stQ.opWrite;
        stD.op        = OP_IDLE;
      end
      default: begin
        stD.op = OP_IDLE;
      end
    endcase

    // check field moves only on a drive ready rise after an operation
    if (driveReady && !stQ.dryQ && stQ.ckPending) begin
      stD.ckPending = 1'b0;
      stD.ckValid   = 1'b1;
      if (stQ.opPe) begin
        stD.ckField = stQ.deadTrack;
      end else begin
        stD.ckField = nrzCheckChar;
      end
    end
    if (!driveReady) begin
      stD.ckValid = 1'b0;
    end

    // reads return the values as they stand before this cycle
    if (tcHit) begin
      stD.rdData = {1'b0, stQ.ignore_frame_count, stQ.frame_count_loaded, stQ.abortOnWrErr,
                    stQ.inhibitShort, stQ.densitySelect,
                    stQ.format, stQ.evenParity, stQ.slave};
    end else if (regSel == TFC_SEL_CHECK_CHAR) begin
      stD.rdData = {7'h00, stQ.ckField};
    end else begin
      stD.rdData = 16'h0000;
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      stQ         <= '0;
      stQ.op      <= OP_IDLE;
      stQ.ckField <= CHECK_RESET;
    end else begin
      stQ <= stD;
    end
  end

  always_comb begin
    regRdData         = stQ.rdData;
    cfg.slave         = stQ.slave;
    cfg.evenParity    = stQ.evenParity && !isPe(stQ.densitySelect);
    cfg.format        = stQ.format;
    cfg.densitySelect = stQ.densitySelect;
    cfg.peMode        = isPe(stQ.densitySelect);
    evt               = stQ.evt;
    frameCountLoaded  = stQ.frame_count_loaded;
    checkField        = stQ.ckField;
    checkValid        = stQ.ckValid;
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  property p_fmt_err;
    (stQ.op == OP_IDLE) && cmd.load && cmd.go && !clrAll && xfer
      && !fmtOk(stQ.format) |=> evt.formatError && evt.abort && !evt.start;
  endproperty
  a_fmt_err: assert property (p_fmt_err) else $error("format error missed");

  property p_nef;
    (stQ.op == OP_IDLE) && cmd.load && cmd.go && !clrAll && motion
      && fmtOk(stQ.format) && !stQ.frame_count_loaded && !stQ.ignore_frame_count
      |=> evt.nonexecutableFunction && !evt.start ##1 stQ.op == OP_IDLE;
  endproperty
  a_nef: assert property (p_nef) else $error("nonexecutable not raised");

  property p_ifc_start;
    (stQ.op == OP_IDLE) && cmd.load && cmd.go && !clrAll && motion
      && fmtOk(stQ.format) && stQ.ignore_frame_count |=> evt.start && stQ.op == OP_RUN;
  endproperty
  a_ifc_start: assert property (p_ifc_start) else $error("ignored count blocked");

  property p_fcl_set;
    frameCounterWritten |=> frameCountLoaded;
  endproperty
  a_fcl_set: assert property (p_fcl_set) else $error("fcl not set");

  property p_fcl_clr;
    (clrAll || frameCounterRollover) && !frameCounterWritten |=> !frameCountLoaded;
  endproperty
  a_fcl_clr: assert property (p_fcl_clr) else $error("fcl not cleared");

  property p_keep_cfg;
    clrAll && !tcWr |=> $stable(cfg) && stQ.ignore_frame_count == $past(stQ.ignore_frame_count);
  endproperty
  a_keep_cfg: assert property (p_keep_cfg) else $error("init altered control");

  property p_wr_abort;
    (stQ.op == OP_RUN) && stQ.opWrite && stQ.abortOnWrErr && anyWrErr
      |=> evt.abort ##1 !evt.done;
  endproperty
  a_wr_abort: assert property (p_wr_abort) else $error("write not aborted");

  property p_short_inh;
    (stQ.op == OP_RUN) && endOfRecord && !frameCounterRollover && !clrAll
      && (stQ.inhibitShort || stQ.ignore_frame_count) && !(stQ.opWrite && stQ.abortOnWrErr && anyWrErr)
      |=> evt.endOfBlockSignal && !evt.frameCountError;
  endproperty
  a_short_inh: assert property (p_short_inh) else $error("short record fce");

  property p_run_hang;
    (stQ.op == OP_WAIT) && runLine && !clrAll && stQ.waitCnt == WAIT_LAST
      |=> evt.frameCountError;
  endproperty
  a_run_hang: assert property (p_run_hang) else $error("run hang no fce");

  property p_ck_valid;
    !driveReady |=> !checkValid;
  endproperty
  a_ck_valid: assert property (p_ck_valid) else $error("check valid w/o ready");

  property p_overflow;
    (stQ.op == OP_RUN) && frameCounterRollover && !clrAll
      && !(stQ.opWrite && stQ.abortOnWrErr && anyWrErr)
      |=> evt.endOfBlockSignal ##1 stQ.op != OP_RUN;
  endproperty
  a_overflow: assert property (p_overflow) else $error("overflow not ending");

  c_start: cover property (evt.start ##[1:300] evt.done);
  c_nef:   cover property (evt.nonexecutableFunction);
  c_hang:  cover property (evt.frameCountError && stQ.op == OP_END);
  c_ck:    cover property ($rose(checkValid) && cfg.peMode);

endmodule : tfc_control_regs

// ==== tfc_pkg.sv ====
// tape formatter control package: register selects, field layout, codes, state types
// assumes one 250 MHz clock; the formatter variant is fixed at build time
package tfc_pkg;

  localparam logic [4:0] TFC_SEL_TAPE_CONTROL = 5'h09;
  localparam logic [4:0] TFC_SEL_CHECK_CHAR   = 5'h0a;

  localparam int TC_SLAVE_LSB  = 0;
  localparam int TC_EVEN_PAR   = 3;
  localparam int TC_FMT_LSB    = 4;
  localparam int TC_DEN_LSB    = 8;
  localparam int TC_INH_SHORT  = 11;
  localparam int TC_ABORT_WERR = 12;
  localparam int TC_FCL        = 13;
  localparam int TC_IFC        = 14;

  localparam logic [3:0] FMT_A_LAST     = 4'h3;
  localparam logic [3:0] FMT_B_FIRST    = 4'hc;
  localparam logic [3:0] FMT_RESERVED   = 4'hf;
  localparam logic [2:0] DEN_PE_FIRST   = 3'h5;
  localparam logic [15:0] TC_RESET      = 16'h0000;
  localparam logic [8:0]  CHECK_RESET   = 9'h000;

  localparam int RUN_DROP_TIME_NS  = 1000;
  localparam int CLK_PERIOD_NS     = 4;
  localparam int RUN_DROP_CYCLES   = RUN_DROP_TIME_NS / CLK_PERIOD_NS;
  localparam int TRACKS            = 9;

  typedef enum logic [3:0] {
    OP_IDLE = 4'b0001,
    OP_RUN  = 4'b0010,
    OP_WAIT = 4'b0100,
    OP_END  = 4'b1000
  } tfc_op_type;

  typedef struct packed {
    logic load;
    logic go;
    logic space;
    logic read;
    logic write;
  } tfc_cmd_type;

  typedef struct packed {
    logic dataBusParity;
    logic correctableCrcError;
    logic longitudinalCheckError;
    logic verticalParityError;
    logic formatterParityError;
  } tfc_err_type;

  typedef struct packed {
    logic start;
    logic abort;
    logic formatError;
    logic nonexecutableFunction;
    logic frameCountError;
    logic endOfBlockSignal;
    logic done;
  } tfc_evt_type;

  typedef struct packed {
    logic [2:0] slave;
    logic       evenParity;
    logic [3:0] format;
    logic [2:0] densitySelect;
    logic       peMode;
  } tfc_cfg_type;

endpackage : tfc_pkg

// ==== tfc_pin_sync.sv ====
// three-stage synchroniser for the per-track signal-loss pins
// assumes pins change slowly against sys_clk; output moves when stages two and three agree
`timescale 1ns/10ps
module tfc_pin_sync (
  input  wire logic                        sys_clk,
  input  wire logic                        reset,
  input  wire logic [tfc_pkg::TRACKS-1:0]  pinIn,
  output      logic [tfc_pkg::TRACKS-1:0]  pinOut
);
  import tfc_pkg::*;

  typedef struct packed {
    logic [TRACKS-1:0] s1;
    logic [TRACKS-1:0] s2;
    logic [TRACKS-1:0] s3;
    logic [TRACKS-1:0] held;
  } tfc_sync_type;

  tfc_sync_type syncQ;
  tfc_sync_type syncD;

  always_comb begin
    syncD    = syncQ;
    syncD.s1 = pinIn;
    syncD.s2 = syncQ.s1;
    syncD.s3 = syncQ.s2;
    for (int i = 0; i < TRACKS; i++) begin
      if (syncQ.s2[i] == syncQ.s3[i]) begin
        syncD.held[i] = syncQ.s3[i];
      end
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      syncQ <= '0;
    end else begin
      syncQ <= syncD;
    end
  end

  assign pinOut = syncQ.held;

endmodule : tfc_pin_sync

// ==== tfc_ctrl_model.sv ====
// controller-side model: raises run on start, drops it after end of block, reports ready
// assumes evt pulses last one sys_clk cycle; holdRun keeps the run line up on purpose
`timescale 1ns/10ps
module tfc_ctrl_model (
  input  wire logic                 sys_clk,
  input  wire logic                 reset,
  input  wire tfc_pkg::tfc_evt_type evt,
  input  wire logic                 holdRun,
  input  wire logic [7:0]           dropDelay,
  output      logic                 runLine,
  output      logic                 driveReady
);
  import tfc_pkg::*;
  int dropCnt;
  int readyCnt;
  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      runLine    <= 1'b0;
      driveReady <= 1'b1;
      dropCnt    <= -1;
      readyCnt   <= 0;
    end else begin
      if (evt.start) begin
        runLine    <= 1'b1;
        driveReady <= 1'b0;
      end
      // slow answers come from a larger dropDelay; holdRun never answers at all
      if (evt.endOfBlockSignal) dropCnt <= dropDelay;
      else if (dropCnt > 0) dropCnt <= dropCnt - 1;
      else if (dropCnt == 0 && !holdRun) begin
        runLine <= 1'b0;
        dropCnt <= -1;
      end
      if (evt.done || evt.abort) begin
        runLine  <= 1'b0;
        dropCnt  <= -1;
        readyCnt <= 2;
      end else if (readyCnt > 1) readyCnt <= readyCnt - 1;
      else if (readyCnt == 1) begin
        driveReady <= 1'b1;
        readyCnt   <= 0;
      end
    end
  end
endmodule : tfc_ctrl_model

// ==== tfc_control_regs_tb.sv ====
// self-checking bench for the tape control and check-character registers
// assumes variant A formatter; controller model sits on the run-line side
`timescale 1ns/10ps
module tfc_control_regs_tb;
  import tfc_pkg::*;
  logic        sys_clk, reset, regWrite, clrSeen, holdRun, checkValid;
  logic [4:0]  regSel, pls;
  logic [15:0] regWrData, regRdData;
  logic [7:0]  dropDelay;
  logic [8:0]  trackLossPins, nrzCheckChar, checkField;
  logic [6:0]  evtSeen;
  logic        runLine, driveReady, frame_count_loaded;
  tfc_cmd_type cmd;
  tfc_err_type errIn;
  tfc_cfg_type cfg;
  tfc_evt_type evt;
  int          badCount, numChecks;

  always #2 sys_clk = ~sys_clk;

  tfc_control_regs dut_u (.sys_clk(sys_clk), .reset(reset), .regSel(regSel),
    .regWrite(regWrite), .regWrData(regWrData), .regRdData(regRdData),
    .initPulse(pls[0]), .driveClear(pls[1]), .cmd(cmd), .errIn(errIn),
    .frameCounterWritten(pls[2]), .frameCounterRollover(pls[3]), .endOfRecord(pls[4]),
    .runLine(runLine), .driveReady(driveReady), .trackLossPins(trackLossPins),
    .nrzCheckChar(nrzCheckChar), .cfg(cfg), .evt(evt), .frameCountLoaded(frame_count_loaded),
    .checkField(checkField), .checkValid(checkValid));

  tfc_ctrl_model model_u (.sys_clk(sys_clk), .reset(reset), .evt(evt), .holdRun(holdRun),
    .dropDelay(dropDelay), .runLine(runLine), .driveReady(driveReady));

  // event pulses are one cycle wide, so collect them between commands
  always @(posedge sys_clk) begin
    if (clrSeen) evtSeen <= '0;
    else evtSeen <= evtSeen | evt;
  end

  task automatic conclude();
    if (badCount == 0 && numChecks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : conclude

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    numChecks++;
    if (got !== exp) begin
      badCount++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic regWr(input logic [4:0] sel, input logic [15:0] data);
    @(posedge sys_clk);
    regSel    <= sel;
    regWrite  <= 1'b1;
    regWrData <= data;
    @(posedge sys_clk);
    regWrite  <= 1'b0;
  endtask : regWr

  task automatic regRd(input logic [4:0] sel, input logic [15:0] exp);
    @(posedge sys_clk);
    regSel <= sel;
    @(posedge sys_clk);
    #1;
    chk("readback", exp, regRdData);
  endtask : regRd

  task automatic pulse(input int idx);
    @(posedge sys_clk);
    pls[idx] <= 1'b1;
    @(posedge sys_clk);
    pls <= '0;
  endtask : pulse

  task automatic issue(input logic [2:0] motion);
    @(posedge sys_clk);
    cmd     <= {2'b11, motion};
    clrSeen <= 1'b1;
    @(posedge sys_clk);
    cmd     <= '0;
    clrSeen <= 1'b0;
  endtask : issue

  task automatic waitEnd(input int lim, input logic [6:0] exp);
    int n;
    n = 0;
    while (evtSeen[0] !== 1'b1 && evtSeen[5] !== 1'b1 && n < lim) begin
      @(posedge sys_clk);
      n++;
    end
    if (n >= lim) begin
      chk("opEnd", 16'h0001, 16'h0000);
      conclude();
    end
    repeat (4) @(posedge sys_clk);
    chk("events", 16'(exp), 16'(evtSeen));
  endtask : waitEnd

  task automatic waitValid(input logic [8:0] exp);
    int n;
    n = 0;
    while (checkValid !== 1'b1 && n < 50) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    if (n >= 50) begin
      chk("checkValid", 16'h0001, 16'h0000);
      conclude();
    end
    chk("checkField", 16'(exp), 16'(checkField));
  endtask : waitValid

  initial begin
    sys_clk = 0; reset = 1; regSel = '0; regWrite = 0; regWrData = '0; pls = '0;
    cmd = '0; errIn = '0; clrSeen = 0; holdRun = 0; dropDelay = 8'h02;
    trackLossPins = '0; nrzCheckChar = 9'h1a5; badCount = 0; numChecks = 0;
    repeat (6) @(posedge sys_clk);
    reset <= 1'b0;
    regRd(5'h09, 16'h0000);
    regRd(5'h0a, 16'h0000);
    regRd(5'h00, 16'h0000);
    regWr(5'h09, 16'hffff);
    regRd(5'h09, 16'h5fff);
    for (int d = 0; d < 8; d++) begin
      regWr(5'h09, 16'h0008 | 16'(d << 8));
      @(posedge sys_clk);
      #1;
      chk("peMode", 16'(d >= 5), 16'(cfg.peMode));
      chk("evenParity", 16'(d < 5), 16'(cfg.evenParity));
    end
    regWr(5'h09, 16'h180d);
    pulse(2);
    regRd(5'h09, 16'h380d);
    pulse(0);
    regRd(5'h09, 16'h180d);
    pulse(2);
    pulse(1);
    regRd(5'h09, 16'h180d);
    chk("cfg", 16'h0b00, 16'(cfg));
    chk("frameCountLoaded", 16'h0000, 16'(frame_count_loaded));
    for (int k = 0; k < 3; k++) begin
      issue(3'(1 << k));
      waitEnd(20, 7'h28);
    end
    // every format code 0 to 15 at NRZ density 4; codes above 3 give a format error
    for (int f = 0; f < 16; f++) begin
      regWr(5'h09, 16'h0400 | 16'(f << 4));
      issue(3'b010);
      waitEnd(20, (f <= 3) ? 7'h28 : 7'h30);
    end
    issue(3'b100);
    waitEnd(20, 7'h28);
    regWr(5'h09, 16'h4400);
    issue(3'b010);
    pulse(4);
    waitEnd(100, 7'h43);
    waitValid(9'h1a5);
    regRd(5'h0a, 16'h01a5);
    regWr(5'h09, 16'h0400);
    pulse(2);
    dropDelay <= 8'h1e;
    issue(3'b010);
    pulse(4);
    waitEnd(100, 7'h47);
    dropDelay <= 8'h02;
    regWr(5'h09, 16'h0c00);
    issue(3'b010);
    pulse(4);
    waitEnd(100, 7'h43);
    regWr(5'h09, 16'h4400);
    holdRun <= 1'b1;
    issue(3'b010);
    pulse(4);
    waitEnd(400, 7'h47);
    holdRun <= 1'b0;
    pulse(2);
    regRd(5'h09, 16'h6400);
    issue(3'b100);
    pulse(3);
    waitEnd(100, 7'h43);
    regRd(5'h09, 16'h4400);
    regWr(5'h09, 16'h5400);
    for (int i = 0; i < 5; i++) begin
      issue(3'b001);
      @(posedge sys_clk);
      errIn <= tfc_err_type'(5'h01 << i);
      @(posedge sys_clk);
      errIn <= '0;
      waitEnd(50, 7'h60);
    end
    regWr(5'h09, 16'h4500);
    issue(3'b010);
    @(posedge sys_clk);
    trackLossPins <= 9'h010;
    repeat (6) @(posedge sys_clk);
    trackLossPins <= '0;
    pulse(4);
    waitEnd(100, 7'h43);
    waitValid(9'h010);
    conclude();
  end
endmodule : tfc_control_regs_tb
